// [gpio_pkg.sv]
// constants for the dual general-purpose port block
// assumes a core external register bus of bank select plus slot select
package gpio_pkg;
  localparam int PORT_W = 16;
  localparam int BANK_W = 2;
  localparam int SLOT_W = 3;
  localparam logic [1:0] BANK_MISC = 2'h1;
  localparam logic [1:0] BANK_PORT = 2'h3;
  localparam logic [2:0] SLOT_PA_DIR = 3'h4;
  localparam logic [2:0] SLOT_PA_DATA = 3'h5;
  localparam logic [2:0] SLOT_PB_DIR = 3'h6;
  localparam logic [2:0] SLOT_PB_DATA = 3'h7;
  localparam logic [2:0] SLOT_MISC = 3'h6;
  localparam int IRQ_LO_BIT = 14;
  localparam int IRQ_HI_BIT = 15;
  localparam logic [15:0] VEC_LO = 16'h3fff;
  localparam logic [15:0] VEC_HI = 16'h3ffd;
  // misc control field positions
  localparam int MISC_DAC_LSB = 0;
  localparam int MISC_WAKE_LSB = 4;
  localparam int MISC_IRQ_LO_EN = 8;
  localparam int MISC_IRQ_HI_EN = 9;
  localparam int WAKE_N = 4;
  localparam logic [15:0] DIR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] MISC_RST = 16'h0000;
endpackage : gpio_pkg

// [irq_edge.sv]
// rising edge detector for one pin interrupt
// assumes the pin is synchronous to i_ref_clk
`timescale 1ns/1ns
module irq_edge (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_pin,
  input wire logic i_arm,
  output logic o_pulse
);
  logic s1_ff;
  logic s2_ff;
  logic prev_ff;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end
  // low then high sample gives a single pulse per edge
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= i_arm & s2_ff & ~prev_ff;
    end
  end
endmodule : irq_edge

// [dual_gpio.sv]
// two 16-bit general-purpose ports with pin interrupts and wake-up pins
// assumes single-cycle core external register accesses by bank and slot
// Function
// - two independent 16-bit ports, port_a and port_b, are provided.
// - every pin of both ports has its own direction bit.
// - data reads return the pins on inputs and the latch on outputs, and data writes drive only output bits.
// - port_b bits 14 and 15 raise interrupts only while they are inputs.
// - each pin interrupt has its own enable and a disabled one is held back.
// - pin interrupts fire on a rising transition, not on a level.
// - bit 14 requests on irq_line_lo with vector 3FFFh, bit 15 on irq_line_hi with 3FFDh.
// - port_a bits 0 to 3 acting as inputs can each be enabled as a wake-up source.
// - registers lie in the external space of four banks of eight slots.
// - bank 3 slot 4 holds port_a direction and slot 5 port_a data.
// - bank 3 slot 6 holds port_b direction and slot 7 port_b data.
// - interrupt and wake-up enables lie in misc control at bank 1 slot 6.
`timescale 1ns/1ns
module dual_gpio #(
  parameter int PW = gpio_pkg::PORT_W
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [gpio_pkg::BANK_W-1:0] i_bank,
  input wire logic [gpio_pkg::SLOT_W-1:0] i_slot,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  input wire logic [PW-1:0] i_port_a,
  output logic [PW-1:0] o_port_a,
  output logic [PW-1:0] o_port_a_oe,
  input wire logic [PW-1:0] i_port_b,
  output logic [PW-1:0] o_port_b,
  output logic [PW-1:0] o_port_b_oe,
  output logic o_irq_line_lo,
  output logic o_irq_line_hi,
  output logic [15:0] o_irq_lo_vector,
  output logic [15:0] o_irq_hi_vector,
  output logic o_wake,
  output logic [3:0] o_tx_pwr_dac
);
  import gpio_pkg::*;

  logic [PW-1:0] a_dir_ff;
  logic [PW-1:0] a_out_ff;
  logic [PW-1:0] b_dir_ff;
  logic [PW-1:0] b_out_ff;
  logic [15:0] misc_ff;
  logic sel_a_dir;
  logic sel_a_data;
  logic sel_b_dir;
  logic sel_b_data;
  logic sel_misc;
  logic [15:0] nxt_rdata;
  logic [WAKE_N-1:0] wake_hit;

  // bank and slot decode
  always_comb begin
    sel_a_dir = 1'b0;
    sel_a_data = 1'b0;
    sel_b_dir = 1'b0;
    sel_b_data = 1'b0;
    sel_misc = 1'b0;
    if (i_bank == BANK_PORT && i_slot == SLOT_PA_DIR) begin
      sel_a_dir = 1'b1;
    end else if (i_bank == BANK_PORT && i_slot == SLOT_PA_DATA) begin
      sel_a_data = 1'b1;
    end else if (i_bank == BANK_PORT && i_slot == SLOT_PB_DIR) begin
      sel_b_dir = 1'b1;
    end else if (i_bank == BANK_PORT && i_slot == SLOT_PB_DATA) begin
      sel_b_data = 1'b1;
    end else if (i_bank == BANK_MISC && i_slot == SLOT_MISC) begin
      sel_misc = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_dir_ff <= PW'(DIR_RST);
      b_dir_ff <= PW'(DIR_RST);
    end else if (i_wr) begin
      if (sel_a_dir) begin
        a_dir_ff <= i_wdata[PW-1:0];
      end
      if (sel_b_dir) begin
        b_dir_ff <= i_wdata[PW-1:0];
      end
    end
  end

  // output latches are written whatever the direction, so a pin turned to output
  // shows the last value software left for it
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_out_ff <= PW'(DATA_RST);
      b_out_ff <= PW'(DATA_RST);
    end else if (i_wr) begin
      if (sel_a_data) begin
        a_out_ff <= i_wdata[PW-1:0];
      end
      if (sel_b_data) begin
        b_out_ff <= i_wdata[PW-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      misc_ff <= MISC_RST;
    end else if (i_wr && sel_misc) begin
      misc_ff <= i_wdata;
    end
  end

  // pins drive only where direction is output
  assign o_port_a = a_out_ff;
  assign o_port_b = b_out_ff;
  assign o_port_a_oe = a_dir_ff;
  assign o_port_b_oe = b_dir_ff;

  // data reads show pin level on inputs and the latch on outputs
  always_comb begin
    nxt_rdata = 16'h0000;
    if (sel_a_dir) begin
      nxt_rdata = 16'(a_dir_ff);
    end else if (sel_a_data) begin
      nxt_rdata = 16'((i_port_a & ~a_dir_ff) | (a_out_ff & a_dir_ff));
    end else if (sel_b_dir) begin
      nxt_rdata = 16'(b_dir_ff);
    end else if (sel_b_data) begin
      nxt_rdata = 16'((i_port_b & ~b_dir_ff) | (b_out_ff & b_dir_ff));
    end else if (sel_misc) begin
      nxt_rdata = misc_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= nxt_rdata;
    end
  end

  irq_edge u_irq_lo (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_port_b[IRQ_LO_BIT]),
    .i_arm(~b_dir_ff[IRQ_LO_BIT] & misc_ff[MISC_IRQ_LO_EN]),
    .o_pulse(o_irq_line_lo)
  );

  irq_edge u_irq_hi (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_port_b[IRQ_HI_BIT]),
    .i_arm(~b_dir_ff[IRQ_HI_BIT] & misc_ff[MISC_IRQ_HI_EN]),
    .o_pulse(o_irq_line_hi)
  );

  assign o_irq_lo_vector = VEC_LO;
  assign o_irq_hi_vector = VEC_HI;

  // debounce and bit-clock alignment live in the sleep logic, not here
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi++) begin : g_wake
      assign wake_hit[gi] = misc_ff[MISC_WAKE_LSB+gi] & ~a_dir_ff[gi] & i_port_a[gi];
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= |wake_hit;
    end
  end

  assign o_tx_pwr_dac = misc_ff[MISC_DAC_LSB+3:MISC_DAC_LSB];
endmodule : dual_gpio

// [dual_gpio_assertions.sv]
// checker for the dual port block: direction register loads, pin irqs, wake, reads
// assumes it is bound to every dual_gpio instance
`timescale 1ns/1ns
module dual_gpio_chk #(
  parameter int PW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_bank,
  input wire logic [2:0] i_slot,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic [PW-1:0] i_port_a,
  input wire logic [PW-1:0] o_port_a_oe,
  input wire logic [PW-1:0] i_port_b,
  input wire logic [PW-1:0] o_port_b_oe,
  input wire logic o_irq_line_lo,
  input wire logic o_irq_line_hi,
  input wire logic o_wake
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_wr(b, s);
    i_wr && i_bank == b && i_slot == s;
  endsequence
  // pin must have been high two cycles back and be an input when the pulse leaves
  sequence s_lo_armed;
    $past(i_port_b[14], 2) && !o_port_b_oe[14];
  endsequence
  property p_dir_a;
    s_wr(2'h3, 3'h4) |=> o_port_a_oe == $past(i_wdata);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("port_a direction not loaded");
  property p_dir_b;
    s_wr(2'h3, 3'h6) |=> o_port_b_oe == $past(i_wdata);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("port_b direction not loaded");
  property p_lo_cause;
    o_irq_line_lo |-> s_lo_armed;
  endproperty
  a_lo_cause: assert property (p_lo_cause) else $error("lo irq without armed pin");
  property p_hi_cause;
    o_irq_line_hi |-> $past(i_port_b[15], 2) && !o_port_b_oe[15];
  endproperty
  a_hi_cause: assert property (p_hi_cause) else $error("hi irq without armed pin");
  property p_lo_one;
    o_irq_line_lo |=> !o_irq_line_lo;
  endproperty
  a_lo_one: assert property (p_lo_one) else $error("lo irq longer than one cycle");
  property p_wake;
    o_wake |-> $past(|(i_port_a[3:0] & ~o_port_a_oe[3:0]));
  endproperty
  a_wake: assert property (p_wake) else $error("wake without input pin high");
  property p_unmapped;
    i_rd && i_bank == 2'h0 |=> o_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule : dual_gpio_chk
bind dual_gpio dual_gpio_chk #(.PW(PW)) i_dual_gpio_chk (.*);

// [pin_partner.sv]
// keypad or host on one port: drives every line the block releases
// assumes oe high means the block drives
`timescale 1ns/1ns
module pin_partner (
  input wire logic [15:0] i_oe,
  input wire logic [15:0] i_out,
  input wire logic [15:0] i_ext,
  output logic [15:0] o_level
);
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule : pin_partner

// [dual_gpio_tb_top.sv]
// self-checking bench for dual_gpio
// assumes pin_partner on both ports and the bound checker
`timescale 1ns/1ns
module dual_gpio_tb_top;
  import gpio_pkg::*;
  logic i_ref_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, o_wake, o_irq_line_lo, o_irq_line_hi;
  logic [1:0] i_bank = 0;
  logic [2:0] i_slot = 0;
  logic [3:0] o_tx_pwr_dac;
  logic [15:0] i_wdata = 0, ext_a = 16'habcd, ext_b = 16'h1a5a, lvl_a, lvl_b;
  logic [15:0] o_rdata, o_port_a, o_port_a_oe, o_port_b, o_port_b_oe, vec_lo, vec_hi;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_lo = 0, n_hi = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    n_lo <= n_lo + o_irq_line_lo;
    n_hi <= n_hi + o_irq_line_hi;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  dual_gpio i_dual_gpio (.i_ref_clk, .i_arst_n, .i_bank, .i_slot, .i_wr, .i_rd, .i_wdata,
    .o_rdata, .i_port_a(lvl_a), .o_port_a, .o_port_a_oe, .i_port_b(lvl_b), .o_port_b,
    .o_port_b_oe, .o_irq_line_lo, .o_irq_line_hi, .o_irq_lo_vector(vec_lo),
    .o_irq_hi_vector(vec_hi),
    .o_wake, .o_tx_pwr_dac);
  pin_partner i_pin_partner_a (.i_oe(o_port_a_oe), .i_out(o_port_a), .i_ext(ext_a),
    .o_level(lvl_a));
  pin_partner i_pin_partner_b (.i_oe(o_port_b_oe), .i_out(o_port_b), .i_ext(ext_b),
    .o_level(lvl_b));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle; ends on the falling edge so results have landed
  task automatic acc(input logic w, input logic [1:0] b, input logic [2:0] s,
                     input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= w;
    i_rd <= !w;
    i_bank <= b;
    i_slot <= s;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 0;
    i_rd <= 0;
    @(negedge i_ref_clk);
  endtask : acc
  task automatic t_ports;
    acc(1, BANK_PORT, SLOT_PA_DIR, 16'h00ff);
    acc(1, BANK_PORT, SLOT_PA_DATA, 16'h1234);
    acc(1, BANK_PORT, SLOT_PB_DIR, 16'h0ff0);
    acc(1, BANK_PORT, SLOT_PB_DATA, 16'h9876);
    acc(1, 2'h2, SLOT_PA_DIR, 16'hffff);
    check(o_port_a_oe, 16'h00ff);
    check(o_port_b, 16'h9876);
    check(o_port_a, 16'h1234);
    check(o_port_b_oe, 16'h0ff0);
    check(vec_lo, 16'h3fff);
    check(vec_hi, 16'h3ffd);
    acc(0, BANK_PORT, SLOT_PA_DATA, 16'h0000);
    check(o_rdata, 16'hab34);
    acc(0, BANK_PORT, SLOT_PB_DATA, 16'h0000);
    check(o_rdata, 16'h187a);
    acc(0, 2'h0, SLOT_PA_DIR, 16'h0000);
    check(o_rdata, 16'h0000);
  endtask : t_ports
  task automatic t_wake;
    acc(1, BANK_PORT, SLOT_PA_DIR, 16'h00f0);
    acc(1, BANK_MISC, SLOT_MISC, 16'h0107);
    @(negedge i_ref_clk);
    check({15'h0000, o_wake}, 16'h0000);
    acc(1, BANK_MISC, SLOT_MISC, 16'h0117);
    @(negedge i_ref_clk);
    check({15'h0000, o_wake}, 16'h0001);
    acc(0, BANK_MISC, SLOT_MISC, 16'h0000);
    check(o_rdata, 16'h0117);
    check({12'h000, o_tx_pwr_dac}, 16'h0007);
  endtask : t_wake
  task automatic set_b(input int k, input logic v);
    @(posedge i_ref_clk);
    ext_b[k] <= v;
    repeat (6) @(negedge i_ref_clk);
  endtask : set_b
  // a pin held high must not fire again; bit 15 rises while disabled, then as output
  task automatic t_irq;
    set_b(14, 1);
    set_b(15, 1);
    check(16'(n_hi), 16'h0000);
    set_b(15, 0);
    acc(1, BANK_MISC, SLOT_MISC, 16'h0317);
    acc(1, BANK_PORT, SLOT_PB_DIR, 16'h8000);
    repeat (6) @(negedge i_ref_clk);
    acc(1, BANK_PORT, SLOT_PB_DIR, 16'h0000);
    set_b(15, 1);
    check(16'(n_hi), 16'h0001);
    check(16'(n_lo), 16'h0001);
  endtask : t_irq
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_arst_n <= 1;
    t_ports();
    t_wake();
    t_irq();
    final_report();
  end
  task automatic final_report;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
endmodule : dual_gpio_tb_top
